// *** core/mpc_core.sv ***
/*
 * mpc_core: PCI master timing and configuration core. Holds cacheline
 * size, latency timer, TRDY wait and retry limits, BAR space types and
 * subsystem ids; times master transactions and raises error flags.
 * Assumes PCI pins and pci_clk_i are asynchronous to mclk_i and that
 * mclk_i is several times faster than the PCI clock.
 */
// Contract
// - cacheline in 32-bit words; write-invalidate only if enabled and burst write
// - cacheline size reads zero after reset until written
// - 8-bit writable latency timer limits bursting while another master requests
// - latency timer low two bits read zero, ignore writes
// - master counts PCI clocks waiting for TRDY; timeout at programmed limit
// - TRDY wait limit zero means wait forever
// - retry limit held in bits 15:8 caps retries per transaction
// - retry limit reached raises read error bit 1 or write error bit 0
// - write error from timeout flushes master write FIFO
// - write FIFO decouples DMA, which may keep queueing after error
// - windows one, two, four default memory; window three I/O
// - subsystem vendor and subsystem id fields are writable
// - config lock set lets the window space type bits be written
// - erroring configuration access returns all ones
`timescale 1ns/100ps
module mpc_core #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
) (
   input wire logic mclk_i,
   input wire logic arst_n_i,
   // configuration pointer/data port
   input wire logic cfg_sel_i,
   input wire logic cfg_we_i,
   input wire logic [5:0] cfg_idx_i,
   input wire logic [31:0] cfg_wdata_i,
   output logic [31:0] cfg_rdata_o,
   output logic cfg_err_o,
   input wire logic cfg_lock_i,
   input wire logic write_invalidate_enable_i,
   // internal master request
   input wire logic mst_req_i,
   input wire logic mst_write_i,
   input wire logic mst_burst_i,
   input wire logic [WIDTH-1:0] wr_data_i,
   input wire logic wr_valid_i,
   output logic wr_ready_o,
   // PCI side pins
   input wire logic pci_clk_i,
   input wire logic pci_trdy_n_i,
   input wire logic pci_stop_n_i,
   input wire logic pci_gnt_n_i,
   output logic [WIDTH-1:0] pci_wdata_o,
   output logic mwi_sel_o,
   output logic burst_end_o,
   output logic wfifo_flush_o,
   output logic [7:0] cls_words_o,
   output logic [3:0] bar_io_o,
   output logic mst_rd_err_o,
   output logic mst_wr_err_o
);

   mpc_wf_if #(.WIDTH(WIDTH)) wf ();

   mpc_wfifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_wfifo (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .wf(wf.fifo)
   );

   logic [7:0] cls_q;
   logic [7:0] lat_q;
   logic [7:0] trdy_lim_q;
   logic [7:0] retry_lim_q;
   logic [15:0] ssv_q;
   logic [15:0] ssid_q;
   logic [31:mpc_pkg::BAR_BASE_LSB] bar_base_q [4];
   logic [3:0] bar_io_q;
   logic [1:0] pend_q;
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   logic pclk_prev_q;
   mpc_pkg::mpc_state_t st_q;
   logic [7:0] wait_cnt_q;
   logic [7:0] retry_cnt_q;
   logic [7:0] lat_cnt_q;
   logic pclk_rise;
   logic trdy_seen;
   logic retry_seen;
   logic trdy_to;
   logic retry_to;
   logic err_evt;
   logic cfg_wr;
   logic bar_hit;
   logic [1:0] bar_sel;

   logic [1:0] pend_set;
   logic [1:0] pend_clr;

   // true when the index falls on one of the four windows
   function automatic logic is_bar(input logic [5:0] idx);
      return (idx >= mpc_pkg::IDX_BAR1) && (idx <= mpc_pkg::IDX_BAR4);
   endfunction

   // readback word for an index; unmapped reads as all ones
   function automatic logic [31:0] rd_word(input logic [5:0] idx);
      logic [31:0] w;
      w = '0;
      if (idx == mpc_pkg::IDX_CLS_LAT) begin
         w[mpc_pkg::CLS_LSB +: 8] = cls_q;
         w[mpc_pkg::LAT_LSB +: 8] = lat_q;
      end else if (idx == mpc_pkg::IDX_TIMEOUT) begin
         w[mpc_pkg::TRDY_LSB +: 8] = trdy_lim_q;
         w[mpc_pkg::RETRY_LSB +: 8] = retry_lim_q;
      end else if (idx == mpc_pkg::IDX_SUBSYS) begin
         w[mpc_pkg::SSV_LSB +: 16] = ssv_q;
         w[mpc_pkg::SSID_LSB +: 16] = ssid_q;
      end else if (idx == mpc_pkg::IDX_PEND) begin
         w[mpc_pkg::PEND_WR_BIT] = pend_q[0];
         w[mpc_pkg::PEND_RD_BIT] = pend_q[1];
      end else if (is_bar(idx)) begin
         w[31:mpc_pkg::BAR_BASE_LSB] = bar_base_q[2'(idx - mpc_pkg::IDX_BAR1)];
         w[mpc_pkg::BAR_IO_BIT] = bar_io_q[2'(idx - mpc_pkg::IDX_BAR1)];
      end else begin
         w = mpc_pkg::RD_ERR_DATA;
      end
      return w;
   endfunction

   function automatic logic is_mapped(input logic [5:0] idx);
      return (idx == mpc_pkg::IDX_CLS_LAT) || (idx == mpc_pkg::IDX_TIMEOUT) ||
         (idx == mpc_pkg::IDX_SUBSYS) || (idx == mpc_pkg::IDX_PEND) || is_bar(idx);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers and PCI clock edge finder
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sync1_q <= 4'hF;
         sync2_q <= 4'hF;
         pclk_prev_q <= 1'b1;
      end else begin
         sync1_q <= {pci_clk_i, pci_trdy_n_i, pci_stop_n_i, pci_gnt_n_i};
         sync2_q <= sync1_q;
         pclk_prev_q <= sync2_q[3];
      end
   end

   assign pclk_rise = sync2_q[3] && !pclk_prev_q;
   assign trdy_seen = pclk_rise && !sync2_q[2];
   assign retry_seen = pclk_rise && sync2_q[2] && !sync2_q[1];
   assign trdy_to = pclk_rise && sync2_q[2] && sync2_q[1] && (trdy_lim_q != 8'h00) &&
      (wait_cnt_q + 8'h01 == trdy_lim_q);
   assign retry_to = retry_seen && (retry_lim_q != 8'h00) &&
      (retry_cnt_q + 8'h01 == retry_lim_q);
   assign err_evt = (st_q == mpc_pkg::MPC_WAIT) && (trdy_to || retry_to);

   ////////////////////////////////////////////////////////////////////////
   // configuration write decode
   assign cfg_wr = cfg_sel_i && cfg_we_i;
   assign bar_hit = is_bar(cfg_idx_i);
   assign bar_sel = 2'(cfg_idx_i - mpc_pkg::IDX_BAR1);

   // cacheline size and latency timer
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cls_q <= mpc_pkg::CLS_RST;
         lat_q <= mpc_pkg::LAT_RST;
      end else if (cfg_wr && cfg_idx_i == mpc_pkg::IDX_CLS_LAT) begin
         cls_q <= cfg_wdata_i[mpc_pkg::CLS_LSB +: 8];
         lat_q <= cfg_wdata_i[mpc_pkg::LAT_LSB +: 8] & mpc_pkg::LAT_RO_MASK;
      end
   end

   // TRDY wait and retry limits
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         trdy_lim_q <= mpc_pkg::TRDY_RST;
         retry_lim_q <= mpc_pkg::RETRY_RST;
      end else if (cfg_wr && cfg_idx_i == mpc_pkg::IDX_TIMEOUT) begin
         trdy_lim_q <= cfg_wdata_i[mpc_pkg::TRDY_LSB +: 8];
         retry_lim_q <= cfg_wdata_i[mpc_pkg::RETRY_LSB +: 8];
      end
   end

   // subsystem ids, always writable
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ssv_q <= mpc_pkg::SSV_RST;
         ssid_q <= mpc_pkg::SSID_RST;
      end else if (cfg_wr && cfg_idx_i == mpc_pkg::IDX_SUBSYS) begin
         ssv_q <= cfg_wdata_i[mpc_pkg::SSV_LSB +: 16];
         ssid_q <= cfg_wdata_i[mpc_pkg::SSID_LSB +: 16];
      end
   end

   // window bases; space type bit writable only under config lock
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (int i = 0; i < 4; i++) begin
            bar_base_q[i] <= '0;
         end
         bar_io_q <= mpc_pkg::BAR_IO_RST;
      end else if (cfg_wr && bar_hit) begin
         bar_base_q[bar_sel] <= cfg_wdata_i[31:mpc_pkg::BAR_BASE_LSB];
         if (cfg_lock_i) begin
            bar_io_q[bar_sel] <= cfg_wdata_i[mpc_pkg::BAR_IO_BIT];
         end
      end
   end

   // error pending flags; new error wins over write-one clear
   assign pend_set = {err_evt && !mst_write_i, err_evt && mst_write_i};
   assign pend_clr = {2{cfg_wr && cfg_idx_i == mpc_pkg::IDX_PEND}} &
      {cfg_wdata_i[mpc_pkg::PEND_RD_BIT], cfg_wdata_i[mpc_pkg::PEND_WR_BIT]};

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pend_q <= 2'h0;
      end else begin
         pend_q <= pend_set | (pend_q & ~pend_clr);
      end
   end

   // registered read data and access error
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cfg_rdata_o <= '0;
         cfg_err_o <= 1'b0;
      end else begin
         cfg_err_o <= cfg_sel_i && !is_mapped(cfg_idx_i);
         if (cfg_sel_i && !cfg_we_i) begin
            cfg_rdata_o <= rd_word(cfg_idx_i);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // master sequencer
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_q <= mpc_pkg::MPC_IDLE;
      end else begin
         unique case (st_q)
            mpc_pkg::MPC_IDLE: begin
               if (mst_req_i) begin
                  st_q <= mpc_pkg::MPC_WAIT;
               end
            end
            mpc_pkg::MPC_WAIT: begin
               if (err_evt) begin
                  st_q <= mpc_pkg::MPC_ERR;
               end else if (!mst_req_i) begin
                  st_q <= mpc_pkg::MPC_IDLE;
               end
            end
            mpc_pkg::MPC_ERR: begin
               if (!mst_req_i) begin
                  st_q <= mpc_pkg::MPC_IDLE;
               end
            end
            default: st_q <= mpc_pkg::MPC_IDLE;
         endcase
      end
   end

   // TRDY wait counter in PCI clocks, cleared on TRDY or retry
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wait_cnt_q <= 8'h00;
      end else if (st_q != mpc_pkg::MPC_WAIT || trdy_seen || retry_seen) begin
         wait_cnt_q <= 8'h00;
      end else if (pclk_rise) begin
         wait_cnt_q <= wait_cnt_q + 8'h01;
      end
   end

   // retry counter per transaction
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         retry_cnt_q <= 8'h00;
      end else if (st_q != mpc_pkg::MPC_WAIT) begin
         retry_cnt_q <= 8'h00;
      end else if (retry_seen) begin
         retry_cnt_q <= retry_cnt_q + 8'h01;
      end
   end

   // latency timer loads at burst start, counts PCI clocks down
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lat_cnt_q <= 8'h00;
      end else if (st_q == mpc_pkg::MPC_IDLE) begin
         lat_cnt_q <= lat_q;
      end else if (pclk_rise && lat_cnt_q != 8'h00) begin
         lat_cnt_q <= lat_cnt_q - 8'h01;
      end
   end

   // burst end at next data phase once expired without grant
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         burst_end_o <= 1'b0;
      end else begin
         burst_end_o <= (st_q == mpc_pkg::MPC_WAIT) && mst_burst_i && trdy_seen &&
            (lat_cnt_q == 8'h00) && sync2_q[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // write FIFO traffic: fill from internal writer, drain on TRDY
   assign wf.push = wr_valid_i;
   assign wf.push_data = wr_data_i;
   assign wf.pop = (st_q == mpc_pkg::MPC_WAIT) && mst_write_i && trdy_seen;
   assign wf.flush = err_evt && mst_write_i;

   // registered outputs
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pci_wdata_o <= '0;
         mwi_sel_o <= 1'b0;
         wfifo_flush_o <= 1'b0;
         cls_words_o <= mpc_pkg::CLS_RST;
         bar_io_o <= mpc_pkg::BAR_IO_RST;
         wr_ready_o <= 1'b0;
         mst_rd_err_o <= 1'b0;
         mst_wr_err_o <= 1'b0;
      end else begin
         pci_wdata_o <= wf.head_data;
         mwi_sel_o <= write_invalidate_enable_i && mst_req_i && mst_write_i && mst_burst_i;
         wfifo_flush_o <= wf.flush;
         cls_words_o <= cls_q;
         bar_io_o <= bar_io_q;
         wr_ready_o <= wf.push_ready && !(wr_valid_i && wf.push_ready);
         mst_rd_err_o <= pend_q[1];
         mst_wr_err_o <= pend_q[0];
      end
   end

endmodule

// *** core/mpc_pkg.sv ***
/*
 * mpc_pkg: register indices, field positions, reset values and state
 * encodings used by the master timing/config core; its write FIFO uses none.
 * Assumes configuration registers are reached by dword index over the
 * pointer/data configuration port.
 */
package mpc_pkg;

   // configuration dword indices
   localparam logic [5:0] IDX_CLS_LAT = 6'h03;  // cacheline size [7:0], latency timer [15:8]
   localparam logic [5:0] IDX_BAR1 = 6'h04;
   localparam logic [5:0] IDX_BAR4 = 6'h07;
   localparam logic [5:0] IDX_SUBSYS = 6'h0B;   // subsystem vendor [15:0], subsystem id [31:16]
   localparam logic [5:0] IDX_TIMEOUT = 6'h10;  // trdy wait limit [7:0], retry limit [15:8]
   localparam logic [5:0] IDX_PEND = 6'h11;     // master error pending, write one to clear

   // field positions
   localparam int CLS_LSB = 0;
   localparam int LAT_LSB = 8;
   localparam int TRDY_LSB = 0;
   localparam int RETRY_LSB = 8;
   localparam int SSV_LSB = 0;
   localparam int SSID_LSB = 16;
   localparam int PEND_WR_BIT = 0;
   localparam int PEND_RD_BIT = 1;
   localparam int BAR_IO_BIT = 0;
   localparam int BAR_BASE_LSB = 4;

   // reset values
   localparam logic [7:0] CLS_RST = 8'h00;
   localparam logic [7:0] LAT_RST = 8'h00;
   localparam logic [7:0] TRDY_RST = 8'h00;
   localparam logic [7:0] RETRY_RST = 8'h00;
   localparam logic [15:0] SSV_RST = 16'h0000;
   localparam logic [15:0] SSID_RST = 16'h0000;
   localparam logic [3:0] BAR_IO_RST = 4'h4;    // window three decodes I/O, others memory
   localparam logic [7:0] LAT_RO_MASK = 8'hFC;  // two low bits hardwired to zero
   localparam logic [31:0] RD_ERR_DATA = 32'hFFFFFFFF;

   // master sequencer
   typedef enum logic [1:0] {
      MPC_IDLE = 2'b00,
      MPC_WAIT = 2'b01,
      MPC_ERR = 2'b11
   } mpc_state_t;

endpackage

// *** core/mpc_wf_if.sv ***
/*
 * mpc_wf_if: link between the core and its master write FIFO.
 * Assumes both ends run on mclk_i.
 */
`timescale 1ns/100ps
interface mpc_wf_if #(parameter int WIDTH = 32);
   logic push;
   logic [WIDTH-1:0] push_data;
   logic push_ready;
   logic pop;
   logic [WIDTH-1:0] head_data;
   logic head_valid;
   logic flush;

   modport core (output push, output push_data, input push_ready, output pop,
      input head_data, input head_valid, output flush);
   modport fifo (input push, input push_data, output push_ready, input pop,
      output head_data, output head_valid, input flush);
endinterface

// *** core/mpc_wfifo.sv ***
/*
 * mpc_wfifo: master write FIFO that decouples the internal writer from
 * the PCI side; flush empties it in one cycle.
 * Assumes a push while full and a pop while empty are never made.
 */
`timescale 1ns/100ps
module mpc_wfifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
) (
   input wire logic mclk_i,
   input wire logic arst_n_i,
   mpc_wf_if.fifo wf
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [AW:0] cnt_q;
   logic [AW:0] cnt_d;
   logic do_push;
   logic do_pop;

   ////////////////////////////////////////////////////////////////////////
   // handshake terms
   assign do_push = wf.push && wf.push_ready;
   assign do_pop = wf.pop && wf.head_valid;
   assign wf.head_data = mem_q[rd_ptr_q];

   always_comb begin
      cnt_d = cnt_q;
      if (wf.flush) begin
         cnt_d = '0;
      end else if (do_push && !do_pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (do_pop && !do_push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // storage
   always_ff @(posedge mclk_i) begin
      if (do_push) begin
         mem_q[wr_ptr_q] <= wf.push_data;
      end
   end

   // pointers, count and registered flags; flush drops pending writes
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         cnt_q <= '0;
         wf.push_ready <= 1'b0;
         wf.head_valid <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         wf.push_ready <= (cnt_d != (AW+1)'(DEPTH));
         wf.head_valid <= (cnt_d != '0);
         if (wf.flush) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
         end else begin
            if (do_push) begin
               wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (do_pop) begin
               rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
            end
         end
      end
   end
endmodule

// *** verif/mpc_core_props.sv ***
/*
 * mpc_chk: port-level assertions for mpc_core.
 * Assumes one clock domain, mclk_i, and is bound to every mpc_core.
 */
`timescale 1ns/100ps
module mpc_chk (
   input wire logic mclk_i,
   input wire logic arst_n_i,
   input wire logic cfg_sel_i,
   input wire logic cfg_we_i,
   input wire logic [5:0] cfg_idx_i,
   input wire logic [31:0] cfg_wdata_i,
   input wire logic [31:0] cfg_rdata_o,
   input wire logic cfg_err_o,
   input wire logic cfg_lock_i,
   input wire logic write_invalidate_enable_i,
   input wire logic mst_req_i,
   input wire logic mst_write_i,
   input wire logic mst_burst_i,
   input wire logic pci_gnt_n_i,
   input wire logic mwi_sel_o,
   input wire logic burst_end_o,
   input wire logic wfifo_flush_o,
   input wire logic [7:0] cls_words_o,
   input wire logic [3:0] bar_io_o,
   input wire logic mst_rd_err_o,
   input wire logic mst_wr_err_o
);
   logic idx_ok;
   // mapped configuration indices
   assign idx_ok = cfg_idx_i inside {6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h0B, 6'h10, 6'h11};
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!arst_n_i);
   ////////////////////////////////////////////////////////////////////////////
   // steps of config reads and write error handling
   sequence s_rd_cls;
      cfg_sel_i && !cfg_we_i && cfg_idx_i == 6'h03;
   endsequence
   sequence s_flush;
      wfifo_flush_o ##1 (!wfifo_flush_o && mst_wr_err_o);
   endsequence
   property p_mwi;
      (write_invalidate_enable_i && mst_req_i && mst_write_i && mst_burst_i) |=> mwi_sel_o;
   endproperty
   property p_mwi_off;
      !write_invalidate_enable_i |=> !mwi_sel_o;
   endproperty
   property p_cls_hold;
      !$stable(cls_words_o) |-> $past(cfg_sel_i && cfg_we_i && cfg_idx_i == 6'h03, 2);
   endproperty
   property p_lat_low;
      s_rd_cls |=> cfg_rdata_o[9:8] == 2'b00;
   endproperty
   property p_unmapped;
      (cfg_sel_i && !cfg_we_i && !idx_ok) |=> cfg_err_o && cfg_rdata_o == 32'hFFFFFFFF;
   endproperty
   property p_err_cause;
      cfg_err_o |-> $past(cfg_sel_i && !idx_ok);
   endproperty
   property p_bar_lock;
      !$stable(bar_io_o) |-> $past(cfg_sel_i && cfg_we_i && cfg_lock_i, 2);
   endproperty
   property p_flush;
      $rose(wfifo_flush_o) |-> s_flush;
   endproperty
   property p_rd_err;
      $rose(mst_rd_err_o) |-> $past(mst_req_i && !mst_write_i, 2);
   endproperty
   property p_end;
      burst_end_o |-> $past(pci_gnt_n_i, 3) && $past(mst_req_i);
   endproperty
   property p_clr;
      $fell(mst_wr_err_o) |-> $past(cfg_sel_i && cfg_we_i && cfg_idx_i == 6'h11 && cfg_wdata_i[0], 2);
   endproperty
   a_mwi: assert property (p_mwi) else $error("write-invalidate select missing");
   a_mwi_off: assert property (p_mwi_off) else $error("write-invalidate select while disabled");
   a_cls_hold: assert property (p_cls_hold) else $error("cacheline size changed unwritten");
   a_lat_low: assert property (p_lat_low) else $error("latency low bits not zero");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not all ones");
   a_err_cause: assert property (p_err_cause) else $error("config error without cause");
   a_bar_lock: assert property (p_bar_lock) else $error("space type changed while unlocked");
   a_flush: assert property (p_flush) else $error("flush not followed by write error");
   a_rd_err: assert property (p_rd_err) else $error("read error without read");
   a_end: assert property (p_end) else $error("burst end while granted");
   a_clr: assert property (p_clr) else $error("write error cleared unasked");
endmodule

bind mpc_core mpc_chk mpc_chk_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .cfg_sel_i(cfg_sel_i),
   .cfg_we_i(cfg_we_i), .cfg_idx_i(cfg_idx_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
   .cfg_err_o(cfg_err_o), .cfg_lock_i(cfg_lock_i), .write_invalidate_enable_i(write_invalidate_enable_i),
   .mst_req_i(mst_req_i), .mst_write_i(mst_write_i), .mst_burst_i(mst_burst_i), .pci_gnt_n_i(pci_gnt_n_i),
   .mwi_sel_o(mwi_sel_o), .burst_end_o(burst_end_o), .wfifo_flush_o(wfifo_flush_o),
   .cls_words_o(cls_words_o), .bar_io_o(bar_io_o), .mst_rd_err_o(mst_rd_err_o), .mst_wr_err_o(mst_wr_err_o));

// *** verif/mpc_pci_far.sv ***
/*
 * mpc_pci_far: other PCI target and arbiter facing the core.
 * Assumes the bench picks the answer mode; pins are pulled up when idle.
 */
`timescale 1ns/100ps
module mpc_pci_far (
   input wire logic [1:0] mode_i,
   input wire logic gnt_off_i,
   output logic pci_clk_o,
   output logic pci_trdy_n_o,
   output logic pci_stop_n_o,
   output logic pci_gnt_n_o
);
   logic tog;
   // free-running bus clock, never stopped
   initial begin
      pci_clk_o = 1'b0;
      tog = 1'b0;
      pci_trdy_n_o = 1'b1;
      pci_stop_n_o = 1'b1;
      pci_gnt_n_o = 1'b0;
   end
   always #62.5 pci_clk_o = ~pci_clk_o;
   // mode 0 silent, 1 prompt, 2 retry, 3 slow ready every other clock
   always @(negedge pci_clk_o) begin
      tog <= ~tog;
      pci_trdy_n_o <= !(mode_i == 2'h1 || (mode_i == 2'h3 && tog));
      pci_stop_n_o <= (mode_i != 2'h2);
      pci_gnt_n_o <= gnt_off_i;
   end
endmodule

// *** verif/pci_master_timing_config_tb.sv ***
/*
 * pci_master_timing_config_tb: config port and master timing tests.
 * Assumes mpc_core with default WIDTH and DEPTH, far side from mpc_pci_far.
 */
`timescale 1ns/100ps
module pci_master_timing_config_tb;
   logic mclk_i, arst_n_i, cfg_sel_i, cfg_we_i, cfg_lock_i, wie, req, wr, burst, wr_valid, e;
   logic [5:0] cfg_idx_i;
   logic [31:0] cfg_wdata_i, d, rdata, wdata_o;
   logic wr_ready, pclk, trdy_n, stop_n, gnt_n, mwi, bend, flush, rd_err, wr_err, err;
   logic [7:0] cls;
   logic [3:0] bar_io;
   logic [1:0] mode;
   logic gnt_off;
   int num_errors, checks_done, n, i;
   mpc_core mpc_core_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .cfg_sel_i(cfg_sel_i), .cfg_we_i(cfg_we_i),
      .cfg_idx_i(cfg_idx_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(rdata), .cfg_err_o(err),
      .cfg_lock_i(cfg_lock_i), .write_invalidate_enable_i(wie), .mst_req_i(req), .mst_write_i(wr),
      .mst_burst_i(burst), .wr_data_i(cfg_wdata_i), .wr_valid_i(wr_valid), .wr_ready_o(wr_ready),
      .pci_clk_i(pclk), .pci_trdy_n_i(trdy_n), .pci_stop_n_i(stop_n), .pci_gnt_n_i(gnt_n),
      .pci_wdata_o(wdata_o), .mwi_sel_o(mwi), .burst_end_o(bend), .wfifo_flush_o(flush),
      .cls_words_o(cls), .bar_io_o(bar_io), .mst_rd_err_o(rd_err), .mst_wr_err_o(wr_err));
   mpc_pci_far mpc_pci_far_i (.mode_i(mode), .gnt_off_i(gnt_off), .pci_clk_o(pclk),
      .pci_trdy_n_o(trdy_n), .pci_stop_n_o(stop_n), .pci_gnt_n_o(gnt_n));
   ////////////////////////////////////////////////////////////////////////////
   // system clock
   always #5 mclk_i = ~mclk_i;
   // verdict and end of run
   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // compare seen against expected
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one config write, strobe held for one edge, then one idle edge
   task automatic cfg_wr(input logic [5:0] idx, input logic [31:0] v);
      cfg_sel_i = 1'b1;
      cfg_we_i = 1'b1;
      cfg_idx_i = idx;
      cfg_wdata_i = v;
      @(negedge mclk_i);
      cfg_sel_i = 1'b0;
      cfg_we_i = 1'b0;
      @(negedge mclk_i);
   endtask
   // one config read; data and error sampled a cycle later
   task automatic cfg_rd(input logic [5:0] idx, output logic [31:0] v, output logic ev);
      cfg_sel_i = 1'b1;
      cfg_idx_i = idx;
      @(negedge mclk_i);
      cfg_sel_i = 1'b0;
      v = rdata;
      ev = err;
      @(negedge mclk_i);
   endtask
   // bounded wait: 0 wr_err, 1 rd_err, 2 burst end, 3 flush, 4 ready
   task automatic wait_for(input int which, input int lim, output int cnt);
      logic hit;
      cnt = 0;
      hit = 1'b0;
      while (!hit && cnt < lim) begin
         @(negedge mclk_i);
         cnt++;
         case (which)
            0: hit = (wr_err === 1'b1);
            1: hit = (rd_err === 1'b1);
            2: hit = (bend === 1'b1);
            3: hit = (flush === 1'b1);
            default: hit = (wr_ready === 1'b1);
         endcase
      end
      if (!hit) begin
         num_errors++;
         $display("[ERR] %0t wait ran out", $time);
         report_and_stop();
      end
   endtask
   // push one word into the master write buffer
   task automatic push(input logic [31:0] v);
      wait_for(4, 20, n);
      wr_valid = 1'b1;
      cfg_wdata_i = v;
      @(negedge mclk_i);
      wr_valid = 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      {mclk_i, arst_n_i, cfg_sel_i, cfg_we_i, cfg_lock_i, wie, req, wr, burst, wr_valid, gnt_off} = '0;
      cfg_idx_i = 6'h00;
      cfg_wdata_i = 32'h0;
      mode = 2'h0;
      num_errors = 0;
      checks_done = 0;
      repeat (3) @(negedge mclk_i);
      arst_n_i = 1'b1;
      cfg_rd(6'h03, d, e);
      check(d, 32'h0);
      check({28'h0, bar_io}, 32'h4);
      for (i = 0; i < 4; i++) begin
         cfg_rd(6'(4 + i), d, e);
         check({31'h0, d[0]}, {31'h0, i == 2});
      end
      cfg_wr(6'h03, 32'h0000FF04);
      cfg_rd(6'h03, d, e);
      check(d, 32'h0000FC04);
      check({24'h0, cls}, 32'h4);
      cfg_wr(6'h0B, 32'hA5C35A3C);
      cfg_rd(6'h0B, d, e);
      check(d, 32'hA5C35A3C);
      cfg_wr(6'h06, 32'h0);
      check({28'h0, bar_io}, 32'h4);
      cfg_lock_i = 1'b1;
      cfg_wr(6'h06, 32'h0);
      cfg_lock_i = 1'b0;
      check({28'h0, bar_io}, 32'h0);
      cfg_rd(6'h3F, d, e);
      check(d, 32'hFFFFFFFF);
      check({31'h0, e}, 32'h1);
      // write timed out waiting for TRDY, full buffer flushed
      cfg_wr(6'h10, 32'h00000003);
      for (i = 0; i < 4; i++) push(32'h11110000 + i);
      check(wdata_o, 32'h11110000);
      {wie, req, wr, burst} = 4'hF;
      repeat (2) @(negedge mclk_i);
      check({31'h0, mwi}, 32'h1);
      wait_for(3, 200, n);
      check({31'h0, n >= 20 && n <= 60}, 32'h1);
      @(negedge mclk_i);
      check({30'h0, wr_err, wr_ready}, 32'h3);
      push(32'h22220000);
      {wie, req, wr, burst} = 4'h0;
      @(negedge mclk_i);
      check({31'h0, mwi}, 32'h0);
      check(wdata_o, 32'h22220000);
      cfg_wr(6'h11, 32'h1);
      repeat (2) @(negedge mclk_i);
      check({31'h0, wr_err}, 32'h0);
      // read retried until the limit
      cfg_wr(6'h10, 32'h00000200);
      mode = 2'h2;
      req = 1'b1;
      wait_for(1, 200, n);
      check({31'h0, n >= 8 && n <= 45}, 32'h1);
      check({31'h0, wr_err}, 32'h0);
      req = 1'b0;
      cfg_wr(6'h11, 32'h2);
      // zero wait limit never times out
      cfg_wr(6'h10, 32'h0);
      mode = 2'h0;
      req = 1'b1;
      repeat (150) @(negedge mclk_i);
      check({30'h0, rd_err, wr_err}, 32'h0);
      req = 1'b0;
      // latency timer spent, grant withdrawn, slow target
      cfg_wr(6'h03, 32'h00000404);
      mode = 2'h3;
      gnt_off = 1'b1;
      {req, burst} = 2'h3;
      wait_for(2, 200, n);
      check({31'h0, n >= 30}, 32'h1);
      {req, burst, gnt_off} = 3'h0;
      mode = 2'h0;
      repeat (4) @(negedge mclk_i);
      report_and_stop();
   end
endmodule
